// *** hdl/imsac_pkg.sv ***
// constants and types for the internal memory and sfr access control block
`default_nettype none
package imsac_pkg;
  // sfr offsets
  localparam logic [7:0] SFR_PWR_CTRL   = 8'h87;
  localparam logic [7:0] SFR_CODE_WAIT  = 8'h92;
  localparam logic [7:0] SFR_PTR0_EXT   = 8'h93;
  localparam logic [7:0] SFR_PTR1_EXT   = 8'h95;
  localparam logic [7:0] SFR_IND_EXT    = 8'hEA;
  localparam logic [7:0] SFR_PORT2      = 8'hA0;
  localparam logic [7:0] SFR_STRETCH    = 8'h8E;
  localparam logic [7:0] SFR_PTR_SEL    = 8'h86;
  // internal ram regions
  localparam logic [7:0] BANK_TOP       = 8'h1F;
  localparam logic [7:0] BIT_BASE       = 8'h20;
  localparam logic [7:0] BIT_TOP        = 8'h2F;
  localparam logic [7:0] UPPER_BASE     = 8'h80;
  localparam int         SCRATCH_BYTES  = 208;
  // reset values and the unmapped sfr read value
  localparam logic [7:0] PWR_CTRL_RST   = 8'h00;
  localparam logic [7:0] CODE_WAIT_RST  = 8'h07;
  localparam logic [7:0] EXT_RST        = 8'h00;
  localparam logic [7:0] STRETCH_RST    = 8'h07;
  localparam logic [7:0] UNMAPPED_VALUE = 8'h00;
  // field positions
  localparam int         PWE_BIT        = 4;
  localparam logic [7:0] PWR_CTRL_MASK  = 8'h90;
  // wait and strobe limits, in clocks
  localparam logic [3:0] CODE_RD_MIN    = 4'h4;
  localparam logic [3:0] STROBE_MIN     = 4'h3;
  localparam logic [3:0] STROBE_MAX     = 4'h8;
  typedef enum logic [1:0] {
    IMSAC_MV_DPTR_RD,
    IMSAC_MV_DPTR_WR,
    IMSAC_MV_RI_RD,
    IMSAC_MV_RI_WR
  } imsac_mv_t;
endpackage
`default_nettype wire

// *** hdl/imsac_counter.sv ***
// down counter that holds a strobe for a loaded number of clocks
`default_nettype none
module imsac_counter #(
  parameter int W = 4
) (
  // clock and reset
  input  wire logic         clk,
  input  wire logic         rst,
  // control
  input  wire logic         load,
  input  wire logic [W-1:0] count,
  output var  logic         busy,
  output var  logic         done
);
  logic [W-1:0] cnt_q;

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
      cnt_q <= '0;
    else if (load)
      cnt_q <= count;
    else if (cnt_q != '0)
      cnt_q <= cnt_q - W'(1);
  end

  always_comb
  begin
    busy = (cnt_q != '0);
    done = (cnt_q == W'(1));
  end
endmodule
`default_nettype wire

// *** hdl/imsac_top.sv ***
// internal memory decode, sfr access and code/data memory access control
// Functional notes
// RULE1: ram bytes 0x00..0x1F are four banks of eight working registers.
// RULE2: sixteen bit-addressable bytes, 128 bits, start at ram byte 0x20.
// RULE3: 208 scratchpad bytes above the bit area, shared with the stack.
// RULE4: indirect access at 0x80..0xFF reaches upper ram.
// RULE5: direct access at 0x80..0xFF reaches the sfr space.
// RULE6: sfrs at addresses ending in hex 0 or 8 are bit addressable.
// RULE7: with write enable set, pointer store writes accumulator to code memory.
// RULE8: with write enable set, register store writes code at port2:register.
// RULE9: software writes zero into power control bits 2..0.
// RULE10: code read time is wait field plus one clocks, 4 to 8.
// RULE11: wait field times fetch and constant reads; code writes use stretch.
// RULE12: code memory writes take at least three wait states.
// RULE13: reset clears both pointer extensions and the indirect extension.
// RULE14: pointer moves take address bits 23:16 from matching extension.
// RULE15: register moves take 23:16 from indirect extension, 15:8 from port2.
// RULE16: pointer select bit zero picks pointer 0, one picks pointer 1.
// RULE17: move strobe lasts 3 to 8 clocks per stretch field.
// RULE18: unimplemented sfr reads return a fixed value without side effect.
`default_nettype none
module imsac_top (
  // clock and reset
  input  wire logic        MCLK,
  input  wire logic        RST,
  // internal ram / sfr access from the core
  input  wire logic        IRAM_REQ,
  input  wire logic        IRAM_WE,
  input  wire logic        IRAM_INDIRECT,
  input  wire logic        IRAM_BIT,
  input  wire logic [7:0]  IRAM_ADDR,
  input  wire logic [7:0]  IRAM_WDATA,
  output logic      [7:0]  IRAM_RDATA,
  output logic             IRAM_RVALID,
  output logic             IRAM_BIT_OK,
  output logic             SFR_HIT,
  // core state used for address forming, write data and strobe length
  input  wire logic [15:0] DPTR0,
  input  wire logic [15:0] DPTR1,
  input  wire logic        PTR_SEL,
  input  wire logic [7:0]  PORT2_REG,
  input  wire logic [7:0]  WORK_REG,
  input  wire logic [7:0]  ACC,
  input  wire logic [2:0]  STRETCH,
  // move and code read requests
  input  wire logic        MV_REQ,
  input  wire logic [1:0]  MV_KIND,
  input  wire logic        CODE_RD_REQ,
  input  wire logic [15:0] CODE_RD_ADDR,
  output logic             MV_BUSY,
  output logic             MV_DONE,
  output logic             CODE_RD_BUSY,
  output logic             CODE_RD_DONE,
  // code memory side
  output logic      [15:0] CODE_ADDR,
  output logic      [7:0]  CODE_WDATA,
  output logic             CODE_RD,
  output logic             CODE_WR,
  // data memory side
  output logic      [23:0] XDATA_ADDR,
  output logic      [7:0]  XDATA_WDATA,
  output logic             XDATA_RD,
  output logic             XDATA_WR
);
  logic [7:0]  ram_q [256];
  logic [7:0]  pwr_q;
  logic [2:0]  wait_q;
  logic [7:0]  ext0_q;
  logic [7:0]  ext1_q;
  logic [7:0]  extr_q;
  logic        sfr_acc;
  logic        sfr_known;
  logic        wr_sfr;
  logic [7:0]  sfr_rd;
  logic        mv_load;
  logic        rd_load;
  logic        mv_busy;
  logic        mv_done;
  logic        rd_busy;
  logic        rd_done;
  logic [3:0]  strobe_len;
  logic [3:0]  read_len;
  logic        code_wr_sel;
  imsac_pkg::imsac_mv_t kind;

  // sfr bits are addressable where the low hex digit is 0 or 8
  function automatic logic bit_capable(input logic [7:0] a);
    bit_capable = (a[2:0] == 3'h0);
  endfunction

  // direct access above 0x7F selects sfr, indirect keeps ram
  assign sfr_acc = IRAM_ADDR[7] && !IRAM_INDIRECT; // [RULE4] [RULE5]
  assign wr_sfr  = IRAM_REQ && IRAM_WE && sfr_acc;

  always_comb
  begin
    sfr_known = 1'b1;
    sfr_rd    = imsac_pkg::UNMAPPED_VALUE;
    case (IRAM_ADDR)
      imsac_pkg::SFR_PWR_CTRL:  sfr_rd = pwr_q;
      imsac_pkg::SFR_CODE_WAIT: sfr_rd = {5'h0_0, wait_q};
      imsac_pkg::SFR_PTR0_EXT:  sfr_rd = ext0_q;
      imsac_pkg::SFR_PTR1_EXT:  sfr_rd = ext1_q;
      imsac_pkg::SFR_IND_EXT:   sfr_rd = extr_q;
      default:                  sfr_known = 1'b0; // [RULE18]
    endcase
  end

  // the full 256-byte array covers banks, bit area, scratchpad and upper ram
  always_ff @(posedge MCLK)
  begin
    if (IRAM_REQ && IRAM_WE && !sfr_acc)
      ram_q[IRAM_ADDR] <= IRAM_WDATA; // [RULE1] [RULE2] [RULE3] [RULE4]
  end

  always_ff @(posedge MCLK or posedge RST)
  begin
    if (RST)
    begin
      IRAM_RDATA  <= 8'h0_0;
      IRAM_RVALID <= 1'b0;
      IRAM_BIT_OK <= 1'b0;
      SFR_HIT     <= 1'b0;
    end
    else
    begin
      IRAM_RVALID <= IRAM_REQ && !IRAM_WE;
      SFR_HIT     <= IRAM_REQ && sfr_acc && sfr_known;
      IRAM_BIT_OK <= IRAM_REQ && IRAM_BIT && (sfr_acc ? bit_capable(IRAM_ADDR) // [RULE6]
                     : (IRAM_ADDR >= imsac_pkg::BIT_BASE && IRAM_ADDR <= imsac_pkg::BIT_TOP)); // [RULE2]
      if (IRAM_REQ && !IRAM_WE)
        IRAM_RDATA <= sfr_acc ? sfr_rd : ram_q[IRAM_ADDR]; // [RULE18]
    end
  end

  // reserved low bits of power control are held at zero in hardware too
  always_ff @(posedge MCLK or posedge RST)
  begin
    if (RST)
      pwr_q <= imsac_pkg::PWR_CTRL_RST;
    else if (wr_sfr && IRAM_ADDR == imsac_pkg::SFR_PWR_CTRL)
      pwr_q <= IRAM_WDATA & imsac_pkg::PWR_CTRL_MASK; // [RULE9]
  end

  always_ff @(posedge MCLK or posedge RST)
  begin
    if (RST)
      wait_q <= imsac_pkg::CODE_WAIT_RST[2:0];
    else if (wr_sfr && IRAM_ADDR == imsac_pkg::SFR_CODE_WAIT)
      wait_q <= IRAM_WDATA[2:0];
  end

  always_ff @(posedge MCLK or posedge RST)
  begin
    if (RST)
    begin
      ext0_q <= imsac_pkg::EXT_RST; // [RULE13]
      ext1_q <= imsac_pkg::EXT_RST;
      extr_q <= imsac_pkg::EXT_RST;
    end
    else if (wr_sfr)
    begin
      if (IRAM_ADDR == imsac_pkg::SFR_PTR0_EXT)
        ext0_q <= IRAM_WDATA;
      if (IRAM_ADDR == imsac_pkg::SFR_PTR1_EXT)
        ext1_q <= IRAM_WDATA;
      if (IRAM_ADDR == imsac_pkg::SFR_IND_EXT)
        extr_q <= IRAM_WDATA;
    end
  end

  // unused wait codes 0..2 are clamped to the shortest legal time
  always_comb
  begin
    read_len   = (wait_q < 3'h3) ? imsac_pkg::CODE_RD_MIN : 4'(wait_q) + 4'h1; // [RULE10] [RULE11]
    strobe_len = (STRETCH < 3'h2) ? imsac_pkg::STROBE_MIN : 4'(STRETCH) + 4'h1; // [RULE11] [RULE12] [RULE17]
  end

  assign kind        = imsac_pkg::imsac_mv_t'(MV_KIND);
  assign mv_load     = MV_REQ && !mv_busy;
  assign rd_load     = CODE_RD_REQ && !rd_busy && !mv_busy && !mv_load;
  assign code_wr_sel = pwr_q[imsac_pkg::PWE_BIT]
                       && (kind == imsac_pkg::IMSAC_MV_DPTR_WR || kind == imsac_pkg::IMSAC_MV_RI_WR);

  imsac_counter #(.W(4)) u_mv (
    .clk   (MCLK),
    .rst   (RST),
    .load  (mv_load),
    .count (strobe_len),
    .busy  (mv_busy),
    .done  (mv_done)
  );

  imsac_counter #(.W(4)) u_rd (
    .clk   (MCLK),
    .rst   (RST),
    .load  (rd_load),
    .count (read_len),
    .busy  (rd_busy),
    .done  (rd_done)
  );

  // address and data are latched at the start and held through a move strobe; a move started during a code read replaces CODE_ADDR
  always_ff @(posedge MCLK or posedge RST)
  begin
    if (RST)
    begin
      CODE_ADDR   <= 16'h0000;
      CODE_WDATA  <= 8'h0_0;
      XDATA_ADDR  <= 24'h00_0000;
      XDATA_WDATA <= 8'h0_0;
    end
    else if (mv_load)
    begin
      case (kind)
        imsac_pkg::IMSAC_MV_DPTR_RD, imsac_pkg::IMSAC_MV_DPTR_WR:
        begin
          XDATA_ADDR <= PTR_SEL ? {ext1_q, DPTR1} : {ext0_q, DPTR0}; // [RULE14] [RULE16]
          CODE_ADDR  <= PTR_SEL ? DPTR1 : DPTR0; // [RULE7] [RULE16]
        end
        default:
        begin
          XDATA_ADDR <= {extr_q, PORT2_REG, WORK_REG}; // [RULE15]
          CODE_ADDR  <= {PORT2_REG, WORK_REG}; // [RULE8]
        end
      endcase
      CODE_WDATA  <= ACC; // [RULE7] [RULE8]
      XDATA_WDATA <= ACC;
    end
    else if (rd_load)
      CODE_ADDR <= CODE_RD_ADDR;
  end

  // code writes steal the move strobe, so data memory sees nothing then
  logic wr_to_code_q;
  logic mv_write_q;
  always_ff @(posedge MCLK or posedge RST)
  begin
    if (RST)
    begin
      wr_to_code_q <= 1'b0;
      mv_write_q   <= 1'b0;
    end
    else if (mv_load)
    begin
      wr_to_code_q <= code_wr_sel;
      mv_write_q   <= kind == imsac_pkg::IMSAC_MV_DPTR_WR || kind == imsac_pkg::IMSAC_MV_RI_WR;
    end
  end

  always_ff @(posedge MCLK or posedge RST)
  begin
    if (RST)
    begin
      CODE_WR      <= 1'b0;
      CODE_RD      <= 1'b0;
      XDATA_RD     <= 1'b0;
      XDATA_WR     <= 1'b0;
      MV_BUSY      <= 1'b0;
      MV_DONE      <= 1'b0;
      CODE_RD_BUSY <= 1'b0;
      CODE_RD_DONE <= 1'b0;
    end
    else
    begin
      // move strobes high for exactly strobe_len clocks, code read strobe for read_len clocks
      CODE_WR      <= mv_load ? code_wr_sel : (CODE_WR && !mv_done); // [RULE7] [RULE8] [RULE17]
      XDATA_WR     <= mv_load ? (!code_wr_sel && (kind == imsac_pkg::IMSAC_MV_DPTR_WR
                                                  || kind == imsac_pkg::IMSAC_MV_RI_WR))
                              : (XDATA_WR && !mv_done);
      XDATA_RD     <= mv_load ? (kind == imsac_pkg::IMSAC_MV_DPTR_RD || kind == imsac_pkg::IMSAC_MV_RI_RD)
                              : (XDATA_RD && !mv_done);
      CODE_RD      <= rd_load ? 1'b1 : (CODE_RD && !rd_done); // [RULE10]
      MV_BUSY      <= mv_load || (mv_busy && !mv_done);
      MV_DONE      <= mv_done;
      CODE_RD_BUSY <= rd_load || (rd_busy && !rd_done);
      CODE_RD_DONE <= rd_done;
    end
  end

  // assertions
  logic [3:0] wr_len_q;
  always_ff @(posedge MCLK or posedge RST)
  begin
    if (RST)
      wr_len_q <= 4'h0;
    else
      wr_len_q <= CODE_WR ? wr_len_q + 4'h1 : 4'h0;
  end

  property p_ext_reset;
    @(posedge MCLK) $fell(RST) |-> (ext0_q == 8'h00 && ext1_q == 8'h00 && extr_q == 8'h00);
  endproperty
  a_ext_reset: assert property (p_ext_reset) else $error("extension not cleared"); // [RULE13]

  property p_direct_sfr;
    @(posedge MCLK) disable iff (RST) (IRAM_REQ && !IRAM_WE && !IRAM_INDIRECT && IRAM_ADDR == 8'h93)
      |=> IRAM_RDATA == $past(ext0_q);
  endproperty
  a_direct_sfr: assert property (p_direct_sfr) else $error("direct high access missed sfr"); // [RULE5]

  property p_indirect_ram;
    @(posedge MCLK) disable iff (RST) (IRAM_REQ && IRAM_WE && IRAM_INDIRECT)
      |=> (ram_q[$past(IRAM_ADDR)] == $past(IRAM_WDATA));
  endproperty
  a_indirect_ram: assert property (p_indirect_ram) else $error("indirect write lost"); // [RULE4]

  property p_bit_ok;
    @(posedge MCLK) disable iff (RST) (IRAM_REQ && IRAM_BIT && sfr_acc && IRAM_ADDR[2:0] != 3'h0) |=> !IRAM_BIT_OK;
  endproperty
  a_bit_ok: assert property (p_bit_ok) else $error("bit access allowed on wrong sfr"); // [RULE6]

  property p_bit_ram;
    @(posedge MCLK) disable iff (RST) (IRAM_REQ && IRAM_BIT && !sfr_acc && (IRAM_ADDR < 8'h20 || IRAM_ADDR > 8'h2F))
      |=> !IRAM_BIT_OK;
  endproperty
  a_bit_ram: assert property (p_bit_ram) else $error("bit access allowed outside bit area"); // [RULE2]

  property p_ptr_ext;
    @(posedge MCLK) disable iff (RST) (mv_load && !MV_KIND[1] && !PTR_SEL)
      |=> XDATA_ADDR == {$past(ext0_q), $past(DPTR0)};
  endproperty
  a_ptr_ext: assert property (p_ptr_ext) else $error("pointer 0 address wrong"); // [RULE14]

  property p_ri_addr;
    @(posedge MCLK) disable iff (RST) (mv_load && MV_KIND[1])
      |=> XDATA_ADDR == {$past(extr_q), $past(PORT2_REG), $past(WORK_REG)};
  endproperty
  a_ri_addr: assert property (p_ri_addr) else $error("register move address wrong"); // [RULE15]

  property p_code_wr_gate;
    @(posedge MCLK) disable iff (RST) $rose(CODE_WR) |-> $past(pwr_q[4]);
  endproperty
  a_code_wr_gate: assert property (p_code_wr_gate) else $error("code write without enable"); // [RULE7]

  property p_wr_route;
    @(posedge MCLK) disable iff (RST) (CODE_WR |-> wr_to_code_q) and (XDATA_WR |-> (mv_write_q && !wr_to_code_q));
  endproperty
  a_wr_route: assert property (p_wr_route) else $error("write strobe on wrong memory"); // [RULE7]

  property p_wr_min;
    @(posedge MCLK) disable iff (RST) $fell(CODE_WR) |-> wr_len_q >= 4'h3;
  endproperty
  a_wr_min: assert property (p_wr_min) else $error("code write strobe too short"); // [RULE12]

  property p_wr_max;
    @(posedge MCLK) disable iff (RST) wr_len_q <= 4'h8;
  endproperty
  a_wr_max: assert property (p_wr_max) else $error("code write strobe too long"); // [RULE17]

  property p_rd_len;
    @(posedge MCLK) disable iff (RST) (rd_load && wait_q == 3'h3) |=> CODE_RD [*4] ##1 !CODE_RD;
  endproperty
  a_rd_len: assert property (p_rd_len) else $error("code read time wrong"); // [RULE10]

  property p_unmapped;
    @(posedge MCLK) disable iff (RST) (IRAM_REQ && !IRAM_WE && sfr_acc && !sfr_known)
      |=> IRAM_RDATA == 8'h00;
  endproperty
  a_unmapped: assert property (p_unmapped) else $error("unmapped sfr read not fixed"); // [RULE18]

  c_code_wr: cover property (@(posedge MCLK) disable iff (RST) $rose(CODE_WR));
  c_code_rd: cover property (@(posedge MCLK) disable iff (RST) $rose(CODE_RD));
  c_xdata_rd: cover property (@(posedge MCLK) disable iff (RST) $rose(XDATA_RD));
endmodule
`default_nettype wire

// *** test/imsac_mem_model.sv ***
// far-side model of code and data memory: times each strobe and captures its cycle
`default_nettype none
module imsac_mem_model (
  // clock
  input  wire logic        clk,
  // code memory side
  input  wire logic [15:0] code_addr,
  input  wire logic [7:0]  code_wdata,
  input  wire logic        code_rd,
  input  wire logic        code_wr,
  // data memory side
  input  wire logic [23:0] xdata_addr,
  input  wire logic [7:0]  xdata_wdata,
  input  wire logic        xdata_rd,
  input  wire logic        xdata_wr,
  // observations
  output var  logic [3:0]  width,
  output var  logic [3:0]  seen,
  output var  logic [23:0] cap_addr,
  output var  logic [7:0]  cap_data
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [3:0] strb;
  logic [3:0] prev_q = 4'h0;
  assign strb = {code_wr, code_rd, xdata_wr, xdata_rd};
  // a strobe after a clock with all strobes low restarts the count so that two cycles in a row are timed apart
  always @(posedge clk)
  begin
    if (strb !== 4'h0)
    begin
      width <= (prev_q === 4'h0) ? 4'h1 : width + 4'h1;
      seen <= strb;
      cap_addr <= (code_wr | code_rd) ? {8'h00, code_addr} : xdata_addr;
      cap_data <= code_wr ? code_wdata : xdata_wdata;
    end
    prev_q <= strb;
  end
endmodule
`default_nettype wire

// *** test/internal_memory_sfr_access_control_bench.sv ***
// self-checking bench for the memory decode and access control block
`default_nettype none
module internal_memory_sfr_access_control_bench;
  timeunit 1ns;
  timeprecision 1ps;
  typedef struct packed {
    logic       we;
    logic       ind;
    logic       bt;
    logic [7:0] a;
    logic [7:0] wd;
    logic [7:0] rd;
    logic       hit;
    logic       bok;
  } imsac_row_t;
  logic        MCLK, RST, IRAM_REQ, IRAM_WE, IRAM_INDIRECT, IRAM_BIT, IRAM_RVALID, IRAM_BIT_OK, SFR_HIT;
  logic        PTR_SEL, MV_REQ, CODE_RD_REQ, MV_BUSY, MV_DONE, CODE_RD_BUSY, CODE_RD_DONE;
  logic        CODE_RD, CODE_WR, XDATA_RD, XDATA_WR;
  logic [7:0]  IRAM_ADDR, IRAM_WDATA, IRAM_RDATA, PORT2_REG, WORK_REG, ACC, CODE_WDATA, XDATA_WDATA, cap_data;
  logic [15:0] DPTR0, DPTR1, CODE_RD_ADDR, CODE_ADDR;
  logic [23:0] XDATA_ADDR, cap_addr, ea;
  logic [2:0]  STRETCH, s;
  logic [1:0]  MV_KIND;
  logic [3:0]  width, seen;
  int          error_cnt, tests_run;
  logic [2:0]  ws [3] = '{3'h7, 3'h3, 3'h1};
  logic [7:0]  ra [5] = '{8'h87, 8'h92, 8'h93, 8'h95, 8'hEA};
  logic [7:0]  rv [5] = '{8'h00, 8'h07, 8'h00, 8'h00, 8'h00};
  // we ind bit, address, write data, read data, sfr hit, bit legal
  imsac_row_t  rows [25] = '{
    {3'b100, 8'h93, 8'h12, 8'h00, 2'b10}, {3'b000, 8'h93, 8'h00, 8'h12, 2'b10},
    {3'b100, 8'h95, 8'h34, 8'h00, 2'b10}, {3'b000, 8'h95, 8'h00, 8'h34, 2'b10},
    {3'b100, 8'hEA, 8'h56, 8'h00, 2'b10}, {3'b000, 8'hEA, 8'h00, 8'h56, 2'b10},
    {3'b100, 8'h92, 8'h03, 8'h00, 2'b10}, {3'b000, 8'h92, 8'h00, 8'h03, 2'b10},
    {3'b100, 8'h87, 8'hF8, 8'h00, 2'b10}, {3'b000, 8'h87, 8'h00, 8'h90, 2'b10},
    {3'b110, 8'h93, 8'hA5, 8'h00, 2'b00}, {3'b010, 8'h93, 8'h00, 8'hA5, 2'b00},
    {3'b000, 8'h93, 8'h00, 8'h12, 2'b10}, {3'b100, 8'h05, 8'h11, 8'h00, 2'b00},
    {3'b000, 8'h05, 8'h00, 8'h11, 2'b00}, {3'b100, 8'h2F, 8'h22, 8'h00, 2'b00},
    {3'b000, 8'h2F, 8'h00, 8'h22, 2'b00}, {3'b100, 8'h7F, 8'h33, 8'h00, 2'b00},
    {3'b000, 8'h7F, 8'h00, 8'h33, 2'b00}, {3'b100, 8'h81, 8'h5A, 8'h00, 2'b00},
    {3'b000, 8'h81, 8'h00, 8'h00, 2'b00}, {3'b001, 8'h88, 8'h00, 8'h00, 2'b01},
    {3'b001, 8'h8A, 8'h00, 8'h00, 2'b00}, {3'b001, 8'h20, 8'h00, 8'h00, 2'b01},
    {3'b001, 8'h30, 8'h00, 8'h00, 2'b00}};

  imsac_top dut_u (
    .MCLK(MCLK), .RST(RST), .IRAM_REQ(IRAM_REQ), .IRAM_WE(IRAM_WE), .IRAM_INDIRECT(IRAM_INDIRECT),
    .IRAM_BIT(IRAM_BIT), .IRAM_ADDR(IRAM_ADDR), .IRAM_WDATA(IRAM_WDATA), .IRAM_RDATA(IRAM_RDATA),
    .IRAM_RVALID(IRAM_RVALID), .IRAM_BIT_OK(IRAM_BIT_OK), .SFR_HIT(SFR_HIT), .DPTR0(DPTR0), .DPTR1(DPTR1),
    .PTR_SEL(PTR_SEL), .PORT2_REG(PORT2_REG), .WORK_REG(WORK_REG), .ACC(ACC), .STRETCH(STRETCH),
    .MV_REQ(MV_REQ), .MV_KIND(MV_KIND), .CODE_RD_REQ(CODE_RD_REQ), .CODE_RD_ADDR(CODE_RD_ADDR),
    .MV_BUSY(MV_BUSY), .MV_DONE(MV_DONE), .CODE_RD_BUSY(CODE_RD_BUSY), .CODE_RD_DONE(CODE_RD_DONE),
    .CODE_ADDR(CODE_ADDR), .CODE_WDATA(CODE_WDATA), .CODE_RD(CODE_RD), .CODE_WR(CODE_WR),
    .XDATA_ADDR(XDATA_ADDR), .XDATA_WDATA(XDATA_WDATA), .XDATA_RD(XDATA_RD), .XDATA_WR(XDATA_WR));

  imsac_mem_model mem_u (
    .clk(MCLK), .code_addr(CODE_ADDR), .code_wdata(CODE_WDATA), .code_rd(CODE_RD), .code_wr(CODE_WR),
    .xdata_addr(XDATA_ADDR), .xdata_wdata(XDATA_WDATA), .xdata_rd(XDATA_RD), .xdata_wr(XDATA_WR),
    .width(width), .seen(seen), .cap_addr(cap_addr), .cap_data(cap_data));

  always #10 MCLK = ~MCLK;

  task automatic chk(input string nm, input logic [23:0] e, input logic [23:0] g);
    tests_run++;
    if (g !== e)
    begin
      error_cnt++;
      $display("MISMATCH %s expected %h seen %h", nm, e, g);
    end
  endtask

  task end_sim;
    $display("checks %0d mismatches %0d", tests_run, error_cnt);
    if (error_cnt == 0 && tests_run > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask

  // bounded wait on busy or done; a hang is counted and ends the run
  task automatic wait_hi(input int n);
    logic [3:0] st;
    for (int i = 0; i < 20; i++)
    begin
      @(posedge MCLK);
      #1;
      st = {CODE_RD_DONE, CODE_RD_BUSY, MV_DONE, MV_BUSY};
      if (st[n] === 1'b1)
        return;
    end
    error_cnt++;
    $display("MISMATCH handshake %0d expected 1 seen 0", n);
    end_sim;
  endtask

  task automatic acc(input imsac_row_t r);
    @(posedge MCLK);
    {IRAM_WE, IRAM_INDIRECT, IRAM_BIT, IRAM_ADDR, IRAM_WDATA} <= {r.we, r.ind, r.bt, r.a, r.wd};
    IRAM_REQ <= 1'b1;
    @(posedge MCLK);
    IRAM_REQ <= 1'b0;
    #1;
  endtask

  // request held until busy is seen, so a refused cycle is simply retried
  task automatic mv(input logic [1:0] k, input logic [2:0] st);
    @(posedge MCLK);
    MV_KIND <= k;
    PTR_SEL <= k[0];
    STRETCH <= st;
    ACC <= {5'h0E, st};
    MV_REQ <= 1'b1;
    wait_hi(0);
    @(posedge MCLK);
    MV_REQ <= 1'b0;
    wait_hi(1);
  endtask

  initial
  begin
    {MCLK, IRAM_REQ, IRAM_WE, IRAM_INDIRECT, IRAM_BIT, MV_REQ, CODE_RD_REQ, PTR_SEL} = '0;
    {IRAM_ADDR, IRAM_WDATA, STRETCH, MV_KIND, CODE_RD_ADDR, ACC} = '0;
    RST = 1'b1;
    DPTR0 = 16'hA1B2;
    DPTR1 = 16'hC3D4;
    PORT2_REG = 8'h9A;
    WORK_REG = 8'h3C;
    error_cnt = 0;
    tests_run = 0;
    repeat (2) @(posedge MCLK);
    RST <= 1'b0;
    foreach (rows[i])
    begin
      acc(rows[i]);
      chk("sfr_hit", rows[i].hit, SFR_HIT);
      if (!rows[i].we && !rows[i].bt)
      begin
        chk("read_valid", 1'b1, IRAM_RVALID);
        chk("read_data", rows[i].rd, IRAM_RDATA);
      end
      if (rows[i].bt)
        chk("bit_ok", rows[i].bok, IRAM_BIT_OK);
    end
    for (int p = 1; p >= 0; p--)
    begin
      acc({3'b100, 8'h87, p ? 8'h10 : 8'h00, 10'h000});
      for (int k = 0; k < 4; k++)
      begin
        s = 3'(2 * k + 1);
        mv(k[1:0], s);
        ea = (k < 2) ? {k[0] ? 8'h34 : 8'h12, k[0] ? DPTR1 : DPTR0} : {8'h56, PORT2_REG, WORK_REG};
        if (p == 1 && k[0])
          ea[23:16] = 8'h00;
        chk("strobe_width", (s < 3'h2) ? 4'h3 : {1'b0, s} + 4'h1, width);
        chk("strobe_kind", !k[0] ? 4'h1 : (p == 1 ? 4'h8 : 4'h2), seen);
        chk("move_addr", ea, cap_addr);
        if (k[0])
          chk("write_data", {5'h0E, s}, cap_data);
      end
    end
    for (int j = 0; j < 3; j++)
    begin
      acc({3'b100, 8'h92, {5'h00, ws[j]}, 10'h000});
      @(posedge MCLK);
      CODE_RD_ADDR <= 16'h5A00 + 16'(j);
      CODE_RD_REQ <= 1'b1;
      wait_hi(2);
      @(posedge MCLK);
      CODE_RD_REQ <= 1'b0;
      wait_hi(3);
      chk("code_rd_width", (ws[j] < 3'h3) ? 4'h4 : {1'b0, ws[j]} + 4'h1, width);
      chk("code_rd_kind", 4'h4, seen);
      chk("code_rd_addr", 24'h00_5A00 + 24'(j), cap_addr);
    end
    // second reset in mid-run, after every register except power control (back at 0x00) was moved off its reset value
    @(posedge MCLK);
    RST <= 1'b1;
    repeat (2) @(posedge MCLK);
    RST <= 1'b0;
    #1;
    chk("idle_after_reset", 6'h00, {MV_BUSY, CODE_RD_BUSY, XDATA_RD, XDATA_WR, CODE_WR, CODE_RD});
    for (int j = 0; j < 5; j++)
    begin
      acc({3'b000, ra[j], 8'h00, 10'h000});
      chk("reset_value", rv[j], IRAM_RDATA);
    end
    end_sim;
  end
endmodule
`default_nettype wire
